// [fbc_pkg.sv]
// Purpose: constants for the flash bus host controller
// Assumes: 10 MHz reference clock, 100 ns period
// Notes: timing figures are plain defaults, set per board
//
// Summary of operation
// - host waits wake-up time before reading
// - host waits recovery before next command only after a reset that caught the flash busy
// - flash reset follows system reset
// - host gives proper command address
// - host never asserts output and write together
package fbc_pkg;
  localparam int CLK_NS = 100;
  localparam int T_RESET_LOW_NS = 25000;
  localparam int T_WAKE_NS = 1000;
  localparam int T_RECOVER_NS = 1000;
  localparam int T_STROBE_NS = 200;
  localparam int T_SETUP_NS = 100;
  localparam int RESET_LOW_CYC = (T_RESET_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_CYC = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (T_RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CNT_W = 12;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_ID = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY = 8'h98;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] STATUS_AFTER_RESET = 8'h80;
  localparam logic [7:0] ID_UPPER_BYTE = 8'h00;
  localparam logic [7:0] STATUS_READY_BIT = 8'h80;
  typedef enum logic [2:0] {
    FBC_RESET = 3'b000,
    FBC_WAKE = 3'b001,
    FBC_IDLE = 3'b010,
    FBC_SETUP = 3'b011,
    FBC_STROBE = 3'b100,
    FBC_HOLD = 3'b101
  } fbc_state_e;
endpackage

// [fbc_wait_if.sv]
`timescale 1ns/1ps
// Purpose: carries the hold-off timer request and state
// Assumes: single clock domain
// Notes: none
interface fbc_wait_if;
  logic start;
  logic [fbc_pkg::CNT_W-1:0] count;
  logic done;
  modport ctrl (output start, output count, input done);
  modport timer (input start, input count, output done);
endinterface

// [fbc_timer.sv]
`timescale 1ns/1ps
// Purpose: loadable down counter for hold-off intervals
// Assumes: start is a one-cycle pulse
// Notes: done is high while counter is zero
module fbc_timer (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  fbc_wait_if.timer w
);
  logic [fbc_pkg::CNT_W-1:0] remain;

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      remain <= '0;
    end else if (w.start) begin
      remain <= w.count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  // plain level, so that a start that depends on done forms no loop
  assign w.done = (remain == '0);
endmodule // fbc_timer

// [fbc_host.sv]
`timescale 1ns/1ps
// Purpose: host controller driving a parallel flash through its pins
// Assumes: flash reset tied to the system reset path
// Notes: one request at a time, ready/valid request port
module fbc_host (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic i_req_write,
  input wire logic [fbc_pkg::ADDR_W-1:0] i_req_addr,
  input wire logic [fbc_pkg::DATA_W-1:0] i_req_wdata,
  input wire logic i_wide,
  output logic o_rsp_valid,
  output logic [fbc_pkg::DATA_W-1:0] o_rsp_rdata,
  output logic o_busy,
  output logic o_reset_powerdown_n,
  output logic o_chip_select_a,
  output logic o_chip_select_b,
  output logic o_chip_select_c,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_width_sel,
  output logic [fbc_pkg::ADDR_W-1:0] o_addr,
  output logic [fbc_pkg::DATA_W-1:0] o_dq_out,
  output logic o_dq_oe,
  input wire logic [fbc_pkg::DATA_W-1:0] i_dq_in,
  input wire logic i_busy_status_pin
);
  fbc_pkg::fbc_state_e state;
  fbc_pkg::fbc_state_e next_state;
  fbc_wait_if w ();
  logic [fbc_pkg::CNT_W-1:0] phase;
  logic is_write;
  logic abort_seen;
  logic [fbc_pkg::DATA_W-1:0] dq_s1;
  logic [fbc_pkg::DATA_W-1:0] dq_s2;
  logic sts_s1;
  logic sts_s2;

  function automatic logic [fbc_pkg::CNT_W-1:0] cyc(input int n);
    cyc = n[fbc_pkg::CNT_W-1:0];
  endfunction

  fbc_timer u_timer (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .w(w.timer)
  );

  // ==========================================================
  // pin synchronisers
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      sts_s1 <= 1'b1;
      sts_s2 <= 1'b1;
    end else begin
      dq_s1 <= i_dq_in;
      dq_s2 <= dq_s1;
      sts_s1 <= i_busy_status_pin;
      sts_s2 <= sts_s1;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    case (state)
      // phase zero is the load cycle, the counter is still empty there
      fbc_pkg::FBC_RESET: if (w.done && phase != '0) next_state = fbc_pkg::FBC_WAKE;
      fbc_pkg::FBC_WAKE: if (w.done && phase != '0) next_state = fbc_pkg::FBC_IDLE;
      fbc_pkg::FBC_IDLE: if (i_req_valid && w.done) next_state = fbc_pkg::FBC_SETUP;
      fbc_pkg::FBC_SETUP: if (w.done) next_state = fbc_pkg::FBC_STROBE;
      fbc_pkg::FBC_STROBE: if (w.done) next_state = fbc_pkg::FBC_HOLD;
      fbc_pkg::FBC_HOLD: next_state = fbc_pkg::FBC_IDLE;
      default: next_state = fbc_pkg::FBC_RESET;
    endcase
  end

  always_comb begin
    w.start = 1'b0;
    w.count = '0;
    case (state)
      fbc_pkg::FBC_RESET: begin
        w.start = (phase == '0);
        w.count = cyc(fbc_pkg::RESET_LOW_CYC);
      end
      fbc_pkg::FBC_WAKE: begin
        w.start = (phase == '0);
        w.count = abort_seen ? cyc(fbc_pkg::RECOVER_CYC) : cyc(fbc_pkg::WAKE_CYC);
      end
      fbc_pkg::FBC_IDLE: begin
        w.start = i_req_valid && w.done;
        w.count = cyc(fbc_pkg::SETUP_CYC);
      end
      fbc_pkg::FBC_SETUP: begin
        w.start = w.done;
        w.count = cyc(fbc_pkg::STROBE_CYC);
      end
      default: begin
        w.start = 1'b0;
        w.count = '0;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= fbc_pkg::FBC_RESET;
      phase <= '0;
    end else begin
      state <= next_state;
      phase <= (next_state == state) ? phase + 1'b1 : '0;
    end
  end

  // flash reset released only after system reset, with pin held low
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reset_powerdown_n <= 1'b0;
      abort_seen <= 1'b0;
    end else begin
      if (state == fbc_pkg::FBC_RESET && w.done && phase != '0) begin
        o_reset_powerdown_n <= 1'b1;
      end
      if (state == fbc_pkg::FBC_RESET && !sts_s2) begin
        abort_seen <= 1'b1;
      end
    end
  end

  // ==========================================================
  // bus pins
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      is_write <= 1'b0;
      o_addr <= '0;
      o_dq_out <= '0;
      o_width_sel <= 1'b0;
      o_chip_select_a <= 1'b1;
      o_chip_select_b <= 1'b1;
      o_chip_select_c <= 1'b0;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_dq_oe <= 1'b0;
    end else begin
      case (state)
        fbc_pkg::FBC_IDLE: begin
          if (next_state == fbc_pkg::FBC_SETUP) begin
            is_write <= i_req_write;
            o_addr <= i_req_addr;
            o_dq_out <= i_req_write ? i_req_wdata : '0;
            o_width_sel <= i_wide;
            o_chip_select_a <= 1'b0;
            o_chip_select_b <= 1'b0;
            o_dq_oe <= i_req_write;
          end
        end
        fbc_pkg::FBC_SETUP: begin
          if (next_state == fbc_pkg::FBC_STROBE) begin
            o_we_n <= !is_write;
            o_oe_n <= is_write;
          end
        end
        fbc_pkg::FBC_STROBE: begin
          if (next_state == fbc_pkg::FBC_HOLD) begin
            o_we_n <= 1'b1;
            o_oe_n <= 1'b1;
          end
        end
        fbc_pkg::FBC_HOLD: begin
          o_chip_select_a <= 1'b1;
          o_chip_select_b <= 1'b1;
          o_dq_oe <= 1'b0;
        end
        default: begin
          o_oe_n <= 1'b1;
          o_we_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // read data return
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= '0;
    end else begin
      o_rsp_valid <= 1'b0;
      if (state == fbc_pkg::FBC_HOLD) begin
        o_rsp_valid <= 1'b1;
        o_rsp_rdata <= is_write ? '0 :
                       (o_width_sel ? dq_s2 : {fbc_pkg::ID_UPPER_BYTE, dq_s2[7:0]});
      end
    end
  end

  assign o_req_ready = (state == fbc_pkg::FBC_IDLE) && w.done;
  assign o_busy = !sts_s2;

  a_no_oe_we: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !(!o_oe_n && !o_we_n)) else $error("oe and we both low");
  a_idle_deselect: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (state == fbc_pkg::FBC_IDLE) |-> (o_chip_select_a && o_chip_select_b))
    else $error("selected while waiting");
  a_we_before_cs: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(o_we_n) |-> !o_chip_select_a) else $error("select lost before strobe");
  a_reset_no_bus: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !o_reset_powerdown_n |-> (o_oe_n && o_we_n)) else $error("bus active in reset");
  a_wake_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    $rose(o_reset_powerdown_n) |-> !o_req_ready [*8]) else $error("ready too soon");
  a_select_pattern: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    o_chip_select_a == o_chip_select_b) else $error("bad select pattern");
  a_read_oe_only: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    !o_oe_n |-> !o_dq_oe) else $error("driving dq during read");
  a_recover_wait: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    (abort_seen && $rose(o_reset_powerdown_n)) |-> o_we_n [*3]) else $error("early write");
endmodule // fbc_host

// [fbc_flash_model.sv]
// Purpose: behavioural flash device seen at its pins
// Assumes: data lines have no pull, status pin has a pull-up
// Notes: id codes are arbitrary
`timescale 1ns/1ps
module fbc_flash_model #(
  parameter logic [7:0] MAKER = 8'h3c, // arbitrary value
  parameter logic [7:0] PART = 8'hc3 // arbitrary value
) (
  input wire logic i_reset_powerdown_n,
  input wire logic i_chip_select_a,
  input wire logic i_chip_select_b,
  input wire logic i_chip_select_c,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_width,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_hdq,
  input wire logic i_hdq_oe,
  input wire logic i_program_enable_supply,
  output logic [15:0] o_dq,
  output logic o_busy_status_pin
);
  // =====
  // state
  logic [7:0] mode = 8'hff;
  logic prog_next = 1'b0;
  logic busy = 1'b0;
  logic [15:0] rd;
  logic [15:0] last = 16'h0000;
  wire en = i_reset_powerdown_n && !(i_chip_select_a && i_chip_select_b) &&
    ((!i_chip_select_a && !i_chip_select_b) || i_chip_select_c);
  wire drive = en && !i_oe_n && i_we_n;
  wire wr_on = en && !i_we_n;
  wire [15:0] m = (busy && mode == 8'h70) ? 16'h0080 : {{8{i_width}}, 8'hff};
  // floating lines show the inverse of the last driven value
  assign o_dq = i_hdq_oe ? i_hdq : drive ? (rd & m) | (~last & ~m) : ~last;
  assign o_busy_status_pin = !busy;
  always_comb begin
    case (mode)
      8'h90: rd = {8'h00, i_addr[1] ? PART : MAKER};
      8'h98: rd = 16'h0051;
      8'h70: rd = {8'h00, !busy, 7'h00};
      default: rd = i_addr[15:0] ^ 16'ha5c3;
    endcase
  end
  always @(negedge drive) last <= rd;
  always @(negedge wr_on) begin
    if (i_reset_powerdown_n) begin
      if (prog_next && i_program_enable_supply) begin
        busy = 1'b1;
        busy <= #2000 1'b0;
      end
      prog_next = (i_hdq[7:0] == 8'h40) && !prog_next;
      if (!busy && !prog_next) mode = i_hdq[7:0];
    end
  end
  always @(negedge i_reset_powerdown_n) begin
    mode = 8'hff;
    prog_next = 1'b0;
    if (busy) busy <= #500 1'b0;
  end
endmodule // fbc_flash_model

// [fbc_host_tb.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: device model on the pins
// Notes: expected read data queued by the driver
`timescale 1ns/1ps
`define FBC_CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module fbc_host_tb;
  localparam logic [7:0] MAKER = 8'h3c; // arbitrary value
  localparam logic [7:0] PART = 8'hc3; // arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic vld = 1'b0;
  logic wr = 1'b0;
  logic [22:0] adr = 23'h0;
  logic [15:0] wd = 16'h0;
  logic wide = 1'b1;
  logic pes = 1'b1;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  int mismatches = 0;
  int checked = 0;
  wire rdy, rv, bsy, rpn, csa, csb, csc, oen, wen, wsel, doe, sts;
  wire [15:0] rdat, dqo, dq;
  wire [22:0] fa;
  always #50 clk = ~clk;
  fbc_host dut (.i_ref_clk(clk), .i_rstn(rstn), .i_req_valid(vld), .o_req_ready(rdy),
    .i_req_write(wr), .i_req_addr(adr), .i_req_wdata(wd), .i_wide(wide),
    .o_rsp_valid(rv), .o_rsp_rdata(rdat), .o_busy(bsy), .o_reset_powerdown_n(rpn),
    .o_chip_select_a(csa), .o_chip_select_b(csb), .o_chip_select_c(csc), .o_oe_n(oen),
    .o_we_n(wen), .o_width_sel(wsel), .o_addr(fa), .o_dq_out(dqo), .o_dq_oe(doe),
    .i_dq_in(dq), .i_busy_status_pin(sts));
  fbc_flash_model #(.MAKER(MAKER), .PART(PART)) flash (.i_reset_powerdown_n(rpn),
    .i_chip_select_a(csa), .i_chip_select_b(csb), .i_chip_select_c(csc), .i_oe_n(oen),
    .i_we_n(wen), .i_width(wsel), .i_addr(fa), .i_hdq(dqo), .i_hdq_oe(doe),
    .i_program_enable_supply(pes), .o_dq(dq),
    .o_busy_status_pin(sts));
  // =====
  // tasks
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [15:0] arr(input logic [22:0] a, input logic x16);
    arr = a[15:0] ^ 16'ha5c3;
    if (!x16) arr[15:8] = 8'h00;
  endfunction
  task automatic req(input logic w, input logic [22:0] a, input logic [15:0] d,
    input logic x16, input logic [15:0] ex);
    int n;
    @(negedge clk);
    vld = 1'b1;
    wr = w;
    adr = a;
    wd = d;
    wide = x16;
    exp_q.push_back(ex);
    for (n = 0; n < 400; n++) begin
      #1;
      if (rdy === 1'b1) break;
      @(negedge clk);
    end
    if (n == 400) begin
      mismatches++;
      give_verdict();
    end
    @(negedge clk);
    vld = 1'b0;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    for (n = 0; n < 40 && bsy !== lvl; n++) @(negedge clk);
    `FBC_CHK(bsy, lvl)
    if (n == 40) give_verdict();
  endtask
  // =====
  // response watcher
  always @(posedge clk) begin
    if (rv === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : ~rdat;
      `FBC_CHK(rdat, e)
    end
  end
  // =====
  // main sequence
  initial begin
    int n;
    logic [22:0] a;
    logic w;
    n = $urandom(14102);
    repeat (3) @(negedge clk);
    `FBC_CHK(rpn, 1'b0)
    rstn = 1'b1;
    for (n = 0; n < 6; n++) begin
      a = 23'($urandom);
      w = 1'($urandom);
      req(1'b0, a, 16'h0, w, arr(a, w));
    end
    $display("test read array done");
    req(1'b1, 23'h0, {8'h00, fbc_pkg::CMD_READ_ID}, 1'b1, 16'h0);
    for (n = 0; n < 4; n++) begin
      req(1'b0, 23'(n), 16'h0, n[0], {8'h00, n[1] ? PART : MAKER});
    end
    $display("test identifier done");
    req(1'b1, 23'h0, {8'h00, fbc_pkg::CMD_READ_QUERY}, 1'b1, 16'h0);
    req(1'b0, 23'h10, 16'h0, 1'b1, 16'h0051);
    req(1'b1, 23'h0, {8'h00, fbc_pkg::CMD_READ_STATUS}, 1'b0, 16'h0);
    req(1'b0, 23'h0, 16'h0, 1'b0, {8'h00, fbc_pkg::STATUS_AFTER_RESET});
    $display("test query and status done");
    pes = 1'b0;
    req(1'b1, 23'h0, 16'h0040, 1'b1, 16'h0);
    req(1'b1, 23'h44, 16'h1234, 1'b1, 16'h0);
    repeat (12) @(negedge clk);
    `FBC_CHK(bsy, 1'b0)
    pes = 1'b1;
    $display("test program lockout done");
    req(1'b1, 23'h0, {8'h00, fbc_pkg::CMD_READ_ID}, 1'b1, 16'h0);
    req(1'b1, 23'h0, 16'h0040, 1'b1, 16'h0);
    req(1'b1, 23'h44, 16'h1234, 1'b1, 16'h0);
    wait_busy(1'b1);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    req(1'b0, 23'h44, 16'h0, 1'b1, arr(23'h44, 1'b1));
    wait_busy(1'b0);
    $display("test abort by reset done");
    for (n = 0; n < 50 && exp_q.size() > 0; n++) @(negedge clk);
    if (n == 50) mismatches++;
    give_verdict();
  end
endmodule // fbc_host_tb
